// ### scer_chk.sv
// assertions on the serial channel error reporter ports
// assumes a bind onto scer_reporter, one clock domain
`timescale 1ns/1ps
module scer_chk (
  input wire ref_clk, input wire rst_b,
  input wire [1:0] protocol_mode,
  input wire carrier_detect_checking, input wire carrier_detect,
  input wire line_connected, input wire no_rx_timeout,
  input wire resp_timeout, input wire tx_timeout,
  input wire rx_char_valid, input wire rx_busy,
  input wire rx_stop_bad, input wire rx_parity_bad,
  input wire tx_req, input wire error_clear_request,
  input wire [15:0] error_code, input wire tx_grant,
  input wire protocol_error_indicator, input wire serial_io_error_indicator,
  input wire parity_error_indicator, input wire channel_error_indicator
);
  // ****************
  // properties
  // ****************
  wire rxv = rx_char_valid && (!carrier_detect_checking || carrier_detect);
  wire ev = no_rx_timeout || resp_timeout || tx_timeout || rx_char_valid
    || tx_req;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  AST_NO_RX: assert property (
    no_rx_timeout && protocol_mode != 2'h3 |=> protocol_error_indicator)
    else $error("no-rx timeout not flagged");
  AST_RESP: assert property (
    resp_timeout && !protocol_mode[0] && !tx_timeout && !rx_char_valid
    && !tx_req |=> error_code == 16'h7F41) else $error("resp code wrong");
  AST_TX_TMO: assert property (
    tx_timeout && protocol_mode != 2'h3 && !rx_char_valid && !tx_req
    |=> error_code == 16'h7F42) else $error("tx timeout code wrong");
  AST_OVR: assert property (rxv && rx_busy |=> serial_io_error_indicator)
    else $error("overrun not flagged");
  AST_FRM: assert property (rxv && rx_stop_bad |=> serial_io_error_indicator)
    else $error("framing not flagged");
  AST_PAR: assert property (rxv && rx_parity_bad |=> parity_error_indicator)
    else $error("parity not flagged");
  AST_CD: assert property (
    rx_char_valid && !rxv && !tx_req
    |=> channel_error_indicator && error_code == 16'h7F6B)
    else $error("carrier-off char not flagged");
  AST_LINE: assert property (
    tx_req && !line_connected && protocol_mode != 2'h3
    |=> error_code == 16'h7F6C && !tx_grant) else $error("no-line wrong");
  AST_GRANT: assert property (tx_grant |-> $past(line_connected))
    else $error("grant without line");
  AST_CLR: assert property (error_clear_request && !ev
    |=> error_code == 16'h0000 && !parity_error_indicator
    && !serial_io_error_indicator) else $error("clear failed");
  AST_HOLD: assert property (!error_clear_request && !ev
    |=> $stable(error_code)) else $error("code not held");
endmodule
bind scer_reporter scer_chk scer_chk_i (.*);

// ### scer_dev.sv
// model of the far-side serial device delivering characters
// assumes calls to send are made from the bench process
`timescale 1ns/1ps
module scer_dev (
  input wire ref_clk,
  output logic carrier_detect, output logic rx_char_valid,
  output logic [7:0] rx_char, output logic rx_busy,
  output logic rx_stop_bad, output logic rx_parity_bad
);
  initial {carrier_detect, rx_char_valid, rx_char, rx_busy} = 11'h400;
  initial {rx_stop_bad, rx_parity_bad} = 2'h0;
  // f: carrier off, busy, bad stop, bad parity
  task send(input logic [7:0] d, input logic [3:0] f);
    @(posedge ref_clk);
    carrier_detect <= !f[3];
    rx_char_valid <= 1'b1;
    rx_char <= d;
    {rx_busy, rx_stop_bad, rx_parity_bad} <= f[2:0];
    @(posedge ref_clk);
    {carrier_detect, rx_char_valid, rx_busy} <= 3'h4;
    {rx_stop_bad, rx_parity_bad} <= 2'h0;
    rx_char <= ~d;
  endtask
endmodule

// ### scer_fifo.v
// small synchronous fifo with valid/ready on both sides
// assumes one clock ref_clk and async active-low reset
`timescale 1ns/1ps
module scer_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // clock and reset
  input wire ref_clk,
  input wire rst_b,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire do_wr;
  wire do_rd;
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign do_wr = in_valid & in_ready;
  assign do_rd = out_valid & out_ready;
  // pointers wrap at depth
  function [AW-1:0] bump;
    input [AW-1:0] p;
    begin
      if (p == DEPTH[AW-1:0] - 1'b1 || DEPTH == (1 << AW) && (&p))
        bump = {AW{1'b0}};
      else
        bump = p + 1'b1;
    end
  endfunction
  always @(posedge ref_clk) begin
    if (do_wr)
      mem[wr_ptr] <= in_data;
  end
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (do_wr)
        wr_ptr <= bump(wr_ptr);
      if (do_rd)
        rd_ptr <= bump(rd_ptr);
      if (do_wr && !do_rd)
        count <= count + 1'b1;
      else if (do_rd && !do_wr)
        count <= count - 1'b1;
    end
  end
endmodule

// ### scer_regs.vh
// constants for the serial channel error reporter
// assumes inclusion by plain verilog design files
`ifndef SCER_REGS_VH
`define SCER_REGS_VH
`define SCER_CODE_NONE 16'h0000
`define SCER_CODE_NO_RX_TMO 16'h7F40
`define SCER_CODE_RESP_TMO 16'h7F41
`define SCER_CODE_TX_TMO 16'h7F42
`define SCER_CODE_OVERRUN 16'h7F67
`define SCER_CODE_FRAMING 16'h7F68
`define SCER_CODE_PARITY 16'h7F69
`define SCER_CODE_BUF_FULL 16'h7F6A
`define SCER_CODE_CD_ERR 16'h7F6B
`define SCER_CODE_NO_LINE 16'h7F6C
`define SCER_PROTO_HOST 2'h0
`define SCER_PROTO_NONPROC 2'h1
`define SCER_PROTO_BIDIR 2'h2
`define SCER_PROTO_PREDEF 2'h3
`define SCER_FIFO_DEPTH 4
`define SCER_DATA_W 8
`endif

// ### scer_reporter.v
// error detection and error-code reporting for one serial channel
// assumes receiver/transmitter/timers upstream give one-cycle event pulses
// Operation
// R1 - timer 0 timeout: 7F40, protocol indicator
// R2 - timer 1 timeout: 7F41, no indicator
// R3 - timer 2 timeout: 7F42, no indicator
// R4 - char before previous processed: overrun 7F67
// R5 - stop bits mismatch: framing 7F68
// R6 - parity mismatch: parity 7F69
// R7 - buffer overflow: drop data, 7F6A
// R8 - char with carrier off: 7F6B
// R9 - no line: refuse transmit, 7F6C
// R10 - clear request clears recorded error info
// R11 - host discards data after framing/parity
// R12 - host uses flow control, reads promptly
// R13 - partner sends only with carrier on
// R14 - multidrop stations interlock transmissions
// R15 - latch last code, hold indicator till clear
`timescale 1ns/1ps
`include "scer_regs.vh"
module scer_reporter #(
  parameter DATA_W = `SCER_DATA_W,
  parameter DEPTH = `SCER_FIFO_DEPTH
) (
  // clock and reset
  input wire ref_clk,
  input wire rst_b,
  // configuration
  input wire [1:0] protocol_mode,
  input wire carrier_detect_checking,
  input wire carrier_detect,
  input wire line_connected,
  // timer expiry pulses
  input wire no_rx_timeout,
  input wire resp_timeout,
  input wire tx_timeout,
  // receiver side
  input wire rx_char_valid,
  input wire [DATA_W-1:0] rx_char,
  input wire rx_busy,
  input wire rx_stop_bad,
  input wire rx_parity_bad,
  // transmit request
  input wire tx_req,
  // host side
  input wire error_clear_request,
  output reg host_rd_valid,
  input wire host_rd_ready,
  output reg [DATA_W-1:0] host_rd_data,
  output reg read_request,
  // reporting
  output reg [15:0] error_code,
  output reg protocol_error_indicator,
  output reg serial_io_error_indicator,
  output reg parity_error_indicator,
  output reg channel_error_indicator,
  output reg tx_grant
);
  // ***************************************************
  // protocol qualifiers
  // ***************************************************
  function proto_has;
    input [1:0] mode;
    input [3:0] mask;
    begin
      proto_has = mask[mode];
    end
  endfunction
  wire no_predef;
  wire host_bidir;
  // modes 0 to 2 run timers 0 and 2 and the line check
  localparam [3:0] MASK_NO_PREDEF = 4'h7;
  // only host-access and bidirectional wait for replies
  localparam [3:0] MASK_HOST_BIDIR = 4'h5;
  assign no_predef = proto_has(protocol_mode, MASK_NO_PREDEF);
  assign host_bidir = proto_has(protocol_mode, MASK_HOST_BIDIR);
  // ***************************************************
  // fifo sizing
  // ***************************************************
  // address bits needed for a fifo of n words
  function integer addr_bits;
    input integer n;
    integer k;
    begin
      addr_bits = 1;
      for (k = 2; k < n; k = k * 2)
        addr_bits = addr_bits + 1;
    end
  endfunction
  localparam FIFO_AW = addr_bits(DEPTH);
  // ***************************************************
  // receive path and fifo
  // ***************************************************
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [DATA_W-1:0] fifo_out_data;
  wire cd_bad;
  wire rx_keep;
  wire buf_full;
  wire pop;
  assign cd_bad = rx_char_valid & carrier_detect_checking & ~carrier_detect;
  assign rx_keep = rx_char_valid & ~cd_bad;
  assign buf_full = rx_keep & ~fifo_in_ready; // R7
  assign pop = fifo_out_valid & (~host_rd_valid | host_rd_ready);
  scer_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .in_valid(rx_keep),
    .in_ready(fifo_in_ready),
    .in_data(rx_char),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out_data)
  );
  // ***************************************************
  // event detection
  // ***************************************************
  wire ev_norx;
  wire ev_resp;
  wire ev_txt;
  wire ev_ovr;
  wire ev_frm;
  wire ev_par;
  wire ev_line;
  assign ev_norx = no_rx_timeout & no_predef; // R1
  assign ev_resp = resp_timeout & host_bidir; // R2
  assign ev_txt = tx_timeout & no_predef; // R3
  assign ev_ovr = rx_char_valid & rx_busy; // R4
  assign ev_frm = rx_char_valid & rx_stop_bad; // R5
  assign ev_par = rx_char_valid & rx_parity_bad; // R6
  assign ev_line = tx_req & ~line_connected & no_predef; // R9
  reg [15:0] next_code;
  reg next_any;
  always @* begin
    next_any = 1'b1;
    if (ev_line)
      next_code = `SCER_CODE_NO_LINE;
    else if (cd_bad)
      next_code = `SCER_CODE_CD_ERR; // R8
    else if (buf_full)
      next_code = `SCER_CODE_BUF_FULL;
    else if (ev_par)
      next_code = `SCER_CODE_PARITY;
    else if (ev_frm)
      next_code = `SCER_CODE_FRAMING;
    else if (ev_ovr)
      next_code = `SCER_CODE_OVERRUN;
    else if (ev_txt)
      next_code = `SCER_CODE_TX_TMO;
    else if (ev_resp)
      next_code = `SCER_CODE_RESP_TMO;
    else if (ev_norx)
      next_code = `SCER_CODE_NO_RX_TMO;
    else begin
      next_code = error_code;
      next_any = 1'b0;
    end
  end
  // ***************************************************
  // sticky indicators
  // ***************************************************
  // a new event wins over a clear in the same cycle
  function sticky;
    input cur;
    input set;
    input clr;
    begin
      sticky = set | (cur & ~clr);
    end
  endfunction
  reg next_protocol_error_indicator;
  reg next_serial_io_error_indicator;
  reg next_parity_error_indicator;
  reg next_channel_error_indicator;
  always @* begin
    next_protocol_error_indicator = sticky(protocol_error_indicator,
      ev_norx, error_clear_request); // R1
    next_serial_io_error_indicator = sticky(serial_io_error_indicator,
      ev_ovr | ev_frm | buf_full, error_clear_request); // R15
    next_parity_error_indicator = sticky(parity_error_indicator,
      ev_par, error_clear_request); // R10
    next_channel_error_indicator = sticky(channel_error_indicator,
      cd_bad | ev_line, error_clear_request); // R8
  end
  // ***************************************************
  // latched code and indicators
  // ***************************************************
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      error_code <= `SCER_CODE_NONE;
      protocol_error_indicator <= 1'b0;
      serial_io_error_indicator <= 1'b0;
      parity_error_indicator <= 1'b0;
      channel_error_indicator <= 1'b0;
      tx_grant <= 1'b0;
    end else begin
      if (next_any)
        error_code <= next_code; // R15
      else if (error_clear_request)
        error_code <= `SCER_CODE_NONE; // R10
      protocol_error_indicator <= next_protocol_error_indicator; // R1
      serial_io_error_indicator <= next_serial_io_error_indicator; // R15
      parity_error_indicator <= next_parity_error_indicator; // R10
      channel_error_indicator <= next_channel_error_indicator; // R8
      tx_grant <= tx_req & line_connected; // R9
    end
  end
  // ***************************************************
  // host read port
  // ***************************************************
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      host_rd_valid <= 1'b0;
      host_rd_data <= {DATA_W{1'b0}};
      read_request <= 1'b0;
    end else begin
      if (pop) begin
        host_rd_valid <= 1'b1;
        host_rd_data <= fifo_out_data;
      end else if (host_rd_ready)
        host_rd_valid <= 1'b0;
      read_request <= fifo_out_valid | (host_rd_valid & ~host_rd_ready);
    end
  end
endmodule

// ### testbench.sv
// self-checking bench for the serial channel error reporter
// assumes scer_reporter, scer_dev and the bound checker
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 0, rst_b = 0, carrier_detect_checking = 0;
  logic line_connected = 0, no_rx_timeout = 0, resp_timeout = 0;
  logic tx_timeout = 0, tx_req = 0, error_clear_request = 0;
  logic host_rd_ready = 1;
  logic [1:0] protocol_mode = 2'h0;
  wire carrier_detect, rx_char_valid, rx_busy, rx_stop_bad, rx_parity_bad;
  wire host_rd_valid, read_request, tx_grant, protocol_error_indicator;
  wire serial_io_error_indicator, parity_error_indicator;
  wire channel_error_indicator;
  wire [7:0] rx_char, host_rd_data;
  wire [15:0] error_code;
  int failures = 0, n_checks = 0;
  scer_reporter scer_reporter_i (.*);
  scer_dev scer_dev_i (.*);
  always #4 ref_clk = ~ref_clk;
  // ****************
  // tasks
  // ****************
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task clr;
    @(posedge ref_clk) error_clear_request <= 1'b1;
    @(posedge ref_clk) error_clear_request <= 1'b0;
    #1 chk("clr", 16'h0000, {error_code | parity_error_indicator});
  endtask
  task t_timers;
    logic [15:0] c;
    for (int m = 0; m < 4; m++) begin
      @(posedge ref_clk) protocol_mode <= m[1:0];
      for (int t = 0; t < 3; t++) begin
        @(posedge ref_clk);
        {no_rx_timeout, resp_timeout, tx_timeout} <= 3'h4 >> t;
        @(posedge ref_clk) {no_rx_timeout, resp_timeout, tx_timeout} <= 3'h0;
        c = (m == 3 || (t == 1 && m == 1)) ? 16'h0 : 16'h7F40 + t[15:0];
        #1 chk("tmo", c, error_code);
        chk("pro", c == 16'h7F40, protocol_error_indicator);
        clr;
      end
    end
  endtask
  task t_rx;
    @(posedge ref_clk) carrier_detect_checking <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      scer_dev_i.send(8'h55, 4'h1 << i);
      #1 chk("rx", i == 3 ? 16'h7F6B : 16'h7F69 - i[15:0], error_code);
      chk("ind", i == 0 ? 1 : i == 3 ? 4 : 2, {channel_error_indicator,
        serial_io_error_indicator, parity_error_indicator});
      repeat (3) @(posedge ref_clk);
      clr;
    end
    @(posedge ref_clk) carrier_detect_checking <= 1'b0;
    scer_dev_i.send(8'h5A, 4'h8);
    #1 chk("cdoff", 16'h0, {error_code | channel_error_indicator});
  endtask
  task t_line;
    @(posedge ref_clk) {protocol_mode, tx_req} <= 3'h1;
    @(posedge ref_clk) tx_req <= 1'b0;
    #1 chk("line", 16'h7F6C, error_code);
    chk("chan", 16'h1, {tx_grant, channel_error_indicator});
    clr;
    @(posedge ref_clk) {line_connected, tx_req} <= 2'h3;
    @(posedge ref_clk) tx_req <= 1'b0;
    #1 chk("grant", 16'h1, tx_grant);
  endtask
  task t_buf;
    int n, m;
    n = 0;
    m = 0;
    @(posedge ref_clk) host_rd_ready <= 1'b0;
    while (n < 6 && error_code !== 16'h7F6A) begin
      scer_dev_i.send(8'hA0 + n[7:0], 4'h0);
      n++;
      repeat (2) @(posedge ref_clk);
    end
    #1 chk("full", 16'h7F6A, error_code);
    chk("sio", 16'h3, {serial_io_error_indicator, read_request});
    chk("refused", 16'h6, n[15:0]);
    @(posedge ref_clk) host_rd_ready <= 1'b1;
    #1;
    for (int k = 0; k < 20; k++) begin
      if (host_rd_valid === 1'b1) begin
        chk("data", 8'hA0 + m[7:0], host_rd_data);
        m++;
      end
      @(posedge ref_clk);
      #1;
    end
    chk("count", n[15:0] - 16'h1, m[15:0]);
    chk("rdreq", 16'h0, read_request);
  endtask
  task conclude;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_timers;
    t_rx;
    t_line;
    t_buf;
    conclude;
  end
  initial begin
    #20000;
    failures++;
    conclude;
  end
endmodule
